//--- hw/pwr_seq_pkg.sv
// package: timing constants, states and grouped signals of the power key reset sequencer
package pwr_seq_pkg;

    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned CLK_PER_MS = CLK_HZ / 1000;

    // printed times, in milliseconds
    localparam int unsigned START_HOLD_MS = 2000;
    localparam int unsigned STOP_HOLD_MS = 3100;
    localparam int unsigned RESET_PULSE_MS = 100;

    // least times, in cycles
    localparam int unsigned START_HOLD_CYC = START_HOLD_MS * CLK_PER_MS;
    localparam int unsigned STOP_HOLD_CYC = STOP_HOLD_MS * CLK_PER_MS;
    localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_MS * CLK_PER_MS;

    // length of the reset pulse the module gives its core, and of the orderly shutdown
    localparam int unsigned CORE_RESET_CYC = 16;
    localparam int unsigned SHUTDOWN_CYC = 64;

    localparam int unsigned CNT_W = 32;

    // argument of the function setting command that asks for a reset
    localparam logic [7:0] FUNC_RESET_ARG = 8'h0F;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_STARTING = 3'b001,
        ST_ON = 3'b010,
        ST_RESETTING = 3'b011,
        ST_STOPPING = 3'b100
    } seq_state_t;

    // software commands from the module's command processor
    typedef struct packed {
        logic power_off_command;
        logic function_command;
        logic [7:0] function_arg;
    } sw_cmd_t;

    // status seen by the rest of the module
    typedef struct packed {
        logic core_on;
        logic core_reset;
        logic deregister;
        logic card_present_detect;
        logic abrupt_off;
    } seq_status_t;

endpackage : pwr_seq_pkg

//--- hw/low_hold_timer.sv
// low-level hold timer: counts cycles a line stays low and flags thresholds
`timescale 1ns/10ps
`default_nettype none

module low_hold_timer #(
    parameter int unsigned CNT_W = 32
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // line under watch
    input wire logic line_n,
    // thresholds in cycles
    input wire logic [CNT_W-1:0] short_cyc,
    input wire logic [CNT_W-1:0] long_cyc,
    // results
    output logic low_now,
    output logic reached_short,
    output logic reached_long,
    output logic released
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic prev_low;
    } timer_state_t;

    timer_state_t s_q;
    timer_state_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.prev_low = ~line_n;
        if (line_n) begin
            s_d.cnt = '0;
        end else if (s_q.cnt != '1) begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign low_now = ~line_n;
    assign reached_short = s_q.cnt >= short_cyc;
    assign reached_long = s_q.cnt >= long_cyc;
    // rising edge of the line after a low spell
    assign released = s_q.prev_low & line_n;
endmodule : low_hold_timer

`default_nettype wire

//--- hw/power_key_reset_sequencer.sv
// power key and external reset sequencer of the module
`timescale 1ns/10ps
`default_nettype none

module power_key_reset_sequencer #(
    parameter int unsigned START_CYC = pwr_seq_pkg::START_HOLD_CYC,
    parameter int unsigned STOP_CYC = pwr_seq_pkg::STOP_HOLD_CYC,
    parameter int unsigned RESET_CYC = pwr_seq_pkg::RESET_PULSE_CYC,
    parameter int unsigned CORE_RST_CYC = pwr_seq_pkg::CORE_RESET_CYC,
    parameter int unsigned SHUT_CYC = pwr_seq_pkg::SHUTDOWN_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // control pins from the host
    input wire logic power_key_n,
    input wire logic external_reset_n,
    // supply monitor: high while supply is good
    input wire logic supply_ok,
    // card slot detect pin
    input wire logic card1_detect_in,
    // software commands
    input wire pwr_seq_pkg::sw_cmd_t sw_cmd,
    // status
    output pwr_seq_pkg::seq_status_t status
);
    import pwr_seq_pkg::*;

    localparam logic [CNT_W-1:0] START_C = CNT_W'(START_CYC);
    localparam logic [CNT_W-1:0] STOP_C = CNT_W'(STOP_CYC);
    localparam logic [CNT_W-1:0] RESET_C = CNT_W'(RESET_CYC);
    localparam logic [CNT_W-1:0] CORE_RST_C = CNT_W'(CORE_RST_CYC);
    localparam logic [CNT_W-1:0] SHUT_C = CNT_W'(SHUT_CYC);

    typedef struct packed {
        seq_state_t st;
        logic [CNT_W-1:0] cnt;
        logic key_armed;
        logic auto_start;
        logic supply_seen;
        seq_status_t out;
    } seq_regs_t;

    seq_regs_t r_q;
    seq_regs_t r_d;

    logic key_low;
    logic key_start;
    logic key_stop;
    logic key_rel;
    logic rst_low;
    logic rst_short;
    logic rst_rel;

    low_hold_timer #(.CNT_W(CNT_W)) u_key_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .line_n(power_key_n),
        .short_cyc(START_C),
        .long_cyc(STOP_C),
        .low_now(key_low),
        .reached_short(key_start),
        .reached_long(key_stop),
        .released(key_rel)
    );

    low_hold_timer #(.CNT_W(CNT_W)) u_rst_timer (
        .ref_clk(ref_clk),
        .srst(srst),
        .line_n(external_reset_n),
        .short_cyc(RESET_C),
        .long_cyc(RESET_C),
        .low_now(rst_low),
        .reached_short(rst_short),
        .reached_long(),
        .released(rst_rel)
    );

    // requests decoded from the pins, the commands and the counter
    logic auto_detect;
    logic key_start_req;
    logic auto_start_req;
    logic pin_reset_req;
    logic cmd_reset_req;
    logic key_stop_req;
    logic cmd_off_req;
    logic core_rst_done;
    logic shut_done;

    assign auto_detect = !r_q.supply_seen && key_low;
    assign key_start_req = key_low && key_start && r_q.key_armed;
    assign auto_start_req = r_q.auto_start && key_low;
    // a reset pulse counts only when long enough and raised again
    assign pin_reset_req = rst_rel && rst_short;
    assign cmd_reset_req = sw_cmd.function_command && (sw_cmd.function_arg == FUNC_RESET_ARG);
    // key stop and power-off command are refused when wired for automatic startup
    assign key_stop_req = !r_q.auto_start && r_q.key_armed && key_rel && key_stop;
    assign cmd_off_req = !r_q.auto_start && sw_cmd.power_off_command;
    assign core_rst_done = r_q.cnt >= CORE_RST_C - 1'b1;
    assign shut_done = r_q.cnt >= SHUT_C - 1'b1;

    // next state of the sequencer
    always_comb begin
        r_d = r_q;
        r_d.out.card_present_detect = card1_detect_in;
        r_d.out.abrupt_off = 1'b0;
        r_d.out.deregister = 1'b0;
        r_d.supply_seen = supply_ok;
        if (r_q.cnt != '1) begin
            r_d.cnt = r_q.cnt + 1'b1;
        end
        // a start press must be released before a new hold counts again
        if (!key_low) begin
            r_d.key_armed = 1'b1;
        end
        if (!supply_ok) begin
            // abrupt loss: no orderly shutdown, no deregistration
            r_d.st = ST_OFF;
            r_d.out.core_on = 1'b0;
            r_d.out.core_reset = 1'b0;
            r_d.out.abrupt_off = r_q.out.core_on;
            r_d.auto_start = 1'b0;
            r_d.key_armed = 1'b1;
        end else begin
            case (r_q.st)
                ST_OFF: begin
                    // key already low when supply rises marks automatic startup
                    if (auto_detect) begin
                        r_d.auto_start = 1'b1;
                    end
                    if (key_start_req) begin
                        r_d.st = ST_STARTING;
                        r_d.cnt = '0;
                        r_d.key_armed = 1'b0;
                    end else if (auto_start_req) begin
                        r_d.st = ST_STARTING;
                        r_d.cnt = '0;
                        r_d.key_armed = 1'b0;
                    end
                end
                ST_STARTING: begin
                    // the core comes up held in reset for a fixed count
                    r_d.out.core_on = 1'b1;
                    r_d.out.core_reset = 1'b1;
                    if (core_rst_done) begin
                        r_d.st = ST_ON;
                        r_d.out.core_reset = 1'b0;
                    end
                end
                ST_ON: begin
                    // resets outrank stops; the pin outranks the command
                    if (pin_reset_req) begin
                        r_d.st = ST_RESETTING;
                        r_d.cnt = '0;
                    end else if (cmd_reset_req) begin
                        r_d.st = ST_RESETTING;
                        r_d.cnt = '0;
                    end else if (key_stop_req) begin
                        r_d.st = ST_STOPPING;
                        r_d.cnt = '0;
                    end else if (cmd_off_req) begin
                        r_d.st = ST_STOPPING;
                        r_d.cnt = '0;
                    end
                end
                ST_RESETTING: begin
                    r_d.out.core_reset = 1'b1;
                    if (core_rst_done) begin
                        r_d.st = ST_ON;
                        r_d.out.core_reset = 1'b0;
                    end
                end
                ST_STOPPING: begin
                    r_d.out.deregister = (r_q.cnt == '0);
                    if (shut_done) begin
                        r_d.st = ST_OFF;
                        r_d.out.core_on = 1'b0;
                        // re-arm the key only if it is already released
                        r_d.key_armed = !key_low;
                    end
                end
                default: begin
                    // unused codes fall back to off
                    r_d.st = ST_OFF;
                end
            endcase
        end
        // held reset pin while running only keeps core_reset at its last value, which is low in ST_ON
        if (r_q.st == ST_ON && rst_low) begin
            r_d.out.core_reset = r_q.out.core_reset;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            r_q <= '{
                st: ST_OFF,
                cnt: '0,
                key_armed: 1'b1,
                auto_start: 1'b0,
                supply_seen: 1'b0,
                out: '0
            };
        end else begin
            r_q <= r_d;
        end
    end

    assign status = r_q.out;
endmodule : power_key_reset_sequencer

`default_nettype wire

//--- test/seq_sva.sv
// checker of the power key reset sequencer ports
`timescale 1ns/10ps
`default_nettype none
module seq_sva #(
    parameter int unsigned START_CYC = pwr_seq_pkg::START_HOLD_CYC,
    parameter int unsigned STOP_CYC = pwr_seq_pkg::STOP_HOLD_CYC,
    parameter int unsigned RESET_CYC = pwr_seq_pkg::RESET_PULSE_CYC,
    parameter int unsigned SHUT_CYC = pwr_seq_pkg::SHUTDOWN_CYC
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // watched ports
    input wire logic power_key_n,
    input wire logic external_reset_n,
    input wire logic supply_ok,
    input wire pwr_seq_pkg::sw_cmd_t sw_cmd,
    input wire pwr_seq_pkg::seq_status_t status
);
    import pwr_seq_pkg::*;
    localparam int SHUT_MAX = SHUT_CYC + 4;
    logic sup_q;
    logic auto_q;
    logic [31:0] key_q;
    logic [31:0] rst_q;
    // low-time counts; auto_q marks a key held low at supply rise
    always_ff @(posedge ref_clk) begin
        // a key held low as reset ends counts as tied low, like a supply rise
        sup_q <= srst ? 1'b0 : supply_ok;
        key_q <= power_key_n ? 32'h0 : key_q + 32'h1;
        rst_q <= external_reset_n ? 32'h0 : rst_q + 32'h1;
        auto_q <= (srst || !supply_ok) ? 1'b0 : (auto_q || (!sup_q && !power_key_n));
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    sequence orderly_s;
        status.core_on [*4] ##[1:SHUT_MAX] !status.core_on;
    endsequence
    start_hold_a: assert property ($rose(status.core_on) |->
        status.core_reset && (auto_q || key_q >= START_CYC)) else $error("early start");
    key_stop_a: assert property ($rose(power_key_n) && key_q >= STOP_CYC && !auto_q
        && status.core_on && !status.core_reset |-> ##[1:3] status.deregister) else $error("no key stop");
    pin_reset_a: assert property ($rose(external_reset_n) && rst_q >= RESET_CYC
        && status.core_on && !status.core_reset |-> ##[1:3] status.core_reset) else $error("no pin reset");
    func_reset_a: assert property (sw_cmd.function_command && sw_cmd.function_arg == FUNC_RESET_ARG
        && status.core_on && !status.core_reset |-> ##[1:3] status.core_reset) else $error("no cmd reset");
    tied_cmd_a: assert property (sw_cmd.power_off_command && auto_q |=> !status.deregister [*4])
        else $error("tied cmd stop");
    orderly_a: assert property (status.deregister |-> orderly_s)
        else $error("not orderly");
    supply_loss_a: assert property ($fell(supply_ok) && status.core_on |->
        ##[1:2] (status.abrupt_off && !status.deregister) ##1 !status.core_on) else $error("not abrupt");
    auto_start_a: assert property ($rose(supply_ok) && !power_key_n |-> ##[1:4] status.core_on)
        else $error("no auto start");
endmodule : seq_sva
bind power_key_reset_sequencer seq_sva #(.START_CYC(START_CYC), .STOP_CYC(STOP_CYC), .RESET_CYC(RESET_CYC),
    .SHUT_CYC(SHUT_CYC)) sva_u (.ref_clk(ref_clk), .srst(srst), .power_key_n(power_key_n),
    .external_reset_n(external_reset_n), .supply_ok(supply_ok), .sw_cmd(sw_cmd), .status(status));
`default_nettype wire

//--- test/host_model.sv
// host model driving the power key and external reset lines
`timescale 1ns/10ps
`default_nettype none
module host_model (
    // clock
    input wire logic ref_clk,
    // open-drain lines, high when released
    output logic power_key_n,
    output logic external_reset_n
);
    initial {power_key_n, external_reset_n} = 2'b11;
    // low pulse of n own-clock cycles, then release
    task automatic pulse(input bit rst, input int n);
        @(negedge ref_clk);
        if (rst) external_reset_n = 1'b0;
        else power_key_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        {power_key_n, external_reset_n} = 2'b11;
    endtask : pulse
    // key tied to ground for automatic startup
    task automatic tie_key(input logic low);
        @(negedge ref_clk);
        power_key_n = !low;
    endtask : tie_key
endmodule : host_model
`default_nettype wire

//--- test/test_power_key_reset_sequencer.sv
// bench of the power key reset sequencer
`timescale 1ns/10ps
`default_nettype none
module test_power_key_reset_sequencer;
    import pwr_seq_pkg::*;
    localparam int START = 20;
    localparam int STOP = 31;
    localparam int RST = 5;
    localparam int SHUT = 8;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic supply_ok = 1'b1;
    logic card1_detect_in = 1'b0;
    wire logic power_key_n;
    wire logic external_reset_n;
    sw_cmd_t sw_cmd = '0;
    seq_status_t status;
    int n_mismatch = 0;
    int checked = 0;
    int cycles = 0;
    int dregs = 0;
    int d0;
    logic hit;
    always #2.5 ref_clk = !ref_clk;
    host_model host_u (.ref_clk(ref_clk), .power_key_n(power_key_n), .external_reset_n(external_reset_n));
    power_key_reset_sequencer #(.START_CYC(START), .STOP_CYC(STOP), .RESET_CYC(RST), .CORE_RST_CYC(4),
        .SHUT_CYC(SHUT)) dut_u (.ref_clk(ref_clk), .srst(srst), .power_key_n(power_key_n),
        .external_reset_n(external_reset_n), .supply_ok(supply_ok), .card1_detect_in(card1_detect_in),
        .sw_cmd(sw_cmd), .status(status));
    always @(posedge ref_clk) begin
        cycles++;
        dregs += int'(status.deregister === 1'b1);
        if (cycles == 2000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: status %b", $time, status);
        end
    endtask : chk
    // hit goes high if status bit b is seen high within lim cycles
    task automatic watch(input int b, input int lim);
        hit = 1'b0;
        repeat (lim) begin
            @(posedge ref_clk);
            #1;
            if (status[b] === 1'b1) hit = 1'b1;
        end
    endtask : watch
    task automatic send(input logic off, input logic [7:0] arg);
        @(negedge ref_clk);
        sw_cmd = '{off, !off, arg};
        @(negedge ref_clk);
        sw_cmd = '0;
    endtask : send
    task automatic t_start;
        for (int v = 1; v >= 0; v--) begin
            @(negedge ref_clk);
            card1_detect_in = v[0];
            watch(1, 2);
            chk(status.card_present_detect, v[0]);
        end
        repeat (8) @(negedge ref_clk); // supply settles before the first press
        host_u.pulse(1'b0, START - 10);
        watch(4, 6);
        chk(hit, 1'b0);
        host_u.pulse(1'b0, START + 10);
        chk(status.core_on, 1'b1);
    endtask : t_start
    task automatic t_reset;
        for (int k = 0; k < 2; k++) begin
            host_u.pulse(1'b1, k ? RST + 3 : 2);
            watch(3, 8);
            chk(hit, k[0]);
        end
        for (int a = 14; a <= 15; a++) begin
            send(1'b0, a[7:0]);
            watch(3, 8);
            chk(hit, a[7:0] == FUNC_RESET_ARG);
        end
    endtask : t_reset
    task automatic t_stop;
        for (int k = 0; k < 2; k++) begin
            d0 = dregs;
            if (k == 0) host_u.pulse(1'b0, STOP + 4);
            else send(1'b1, 8'h00);
            repeat (SHUT + 8) @(negedge ref_clk);
            chk(status.core_on, 1'b0);
            chk(dregs == d0 + 1, 1'b1);
            if (k == 1) begin
                // supply removed only after an orderly stop: no abrupt-off pulse
                @(negedge ref_clk);
                supply_ok = 1'b0;
                watch(0, 4);
                chk(hit, 1'b0);
                @(negedge ref_clk);
                supply_ok = 1'b1;
            end
            host_u.pulse(1'b0, START + 10);
        end
    endtask : t_stop
    task automatic t_auto;
        for (int k = 0; k < 2; k++) begin
            d0 = dregs;
            @(negedge ref_clk);
            supply_ok = 1'b0;
            watch(0, 4);
            chk(hit && !status.core_on && dregs == d0, 1'b1);
            if (k == 0) begin
                host_u.tie_key(1'b1);
                @(negedge ref_clk);
                supply_ok = 1'b1;
                watch(4, 6);
                chk(hit, 1'b1);
                send(1'b1, 8'h00);
                host_u.tie_key(1'b0);
                repeat (SHUT + 8) @(negedge ref_clk);
                chk(status.core_on && dregs == d0, 1'b1);
            end
        end
    endtask : t_auto
    task automatic results;
        $display("mismatches %0d, checks %0d", n_mismatch, checked);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        srst = 1'b0;
        t_start();
        t_reset();
        t_stop();
        t_auto();
        results();
    end
endmodule : test_power_key_reset_sequencer
`default_nettype wire
